// ===== hdl/adcr_pkg.sv
package adcr_pkg;

    // ------------------------------------------------------------
    // register map (word index, byte address is four times it)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_RESULT_LOW = 6'h04;
    localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
    localparam logic [5:0] IDX_CONTROL_STATUS = 6'h06;
    localparam logic [5:0] IDX_INPUT_SELECT = 6'h07;

    // ------------------------------------------------------------
    // control/status and input select field positions, reset byte
    // ------------------------------------------------------------
    localparam int CS_ENABLE = 7;
    localparam int CS_START = 6;
    localparam int CS_FREE_RUN = 5;
    localparam int CS_DONE_FLAG = 4;
    localparam int CS_DONE_IE = 3;
    localparam int SEL_LEFT_JUSTIFY = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // conversion lengths in converter clocks
    // ------------------------------------------------------------
    localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
    localparam logic [4:0] EXTENDED_CYCLES = 5'h19;

    // ------------------------------------------------------------
    // input selector codes
    // ------------------------------------------------------------
    localparam logic [4:0] LAST_SINGLE_CODE = 5'h0a;
    localparam logic [4:0] BANDGAP_CODE = 5'h1e;
    localparam logic [4:0] GROUND_CODE = 5'h1f;

    typedef enum {ST_IDLE, ST_CONVERT} adcr_state_e;

    typedef struct packed {
        logic useSupply;
        logic useExternalPin;
        logic useInternalRef;
        logic internalRefWithCap;
        logic singleEnded;
        logic differential;
        logic bandgap;
        logic ground;
        logic [3:0] positiveInput;
        logic [3:0] negativeInput;
        logic gain20x;
    } adcr_route_s;

endpackage

// ===== hdl/adcr_control.sv
// Functional notes
// (R1) reference code: 00 supply, 01 external pin, 10 internal, 11 internal+cap
// (R2) reference/channel writes during a conversion apply once it completes
// (R3) software should discard first result after changing the reference
// (R4) justify bit 0 right, 1 left; affects presented data immediately
// (R5) input codes: 0-10 single, 11-29 differential pairs, 30 bandgap, 31 ground
// (R6) codes 01101,10001,10110,11011 short both inputs at 20x for offset
// (R7) enable turns converter on; clearing it aborts a running conversion
// (R8) software writes start per single conversion, once for free-running
// (R9) first start after enabling runs a dummy initialisation conversion first
// (R10) start reads 1 while converting, including dummy, until real one ends
// (R11) writing 0 to start is ignored
// (R12) free-run converts continuously; clearing it ends free-running
// (R13) done flag sets on completion; cleared by vector taken or writing 1
// (R14) interrupt request while flag, enable and global enable all set
// (R15) software should avoid read-modify-write on the control register
// (R16) prescaler: 000/001 divide 2, then 4,8,16,32,64,128
// (R17) right: high=bits9:8 in 1:0; left: high=9:2, low 7:6=1:0
// (R18) software reads low result byte before the high byte
// (R19) results stored as converter delivers: unsigned magnitude 000 to 3ff
// (R20) normal conversion 13 converter clocks, first after enable 25
// (R21) start on next converter tick; free-run restarts immediately
// (R22) after low byte read, result frozen until high byte read
// (R23) prescaler counts only while enabled, restarting from zero
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcr_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [9:0] conversionResult,
    input wire logic globalIntEnable,
    input wire logic vectorTaken,
    output logic converterOn,
    output logic converterTick,
    output logic converting,
    output logic conversionDone,
    output adcr_pkg::adcr_route_s analogRoute,
    output logic doneIrq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adcr_pkg::adcr_state_e stateQ, stateD;
    logic enableQ, enableD, freeRunQ, freeRunD, doneIeQ, doneIeD;
    logic flagQ, flagD, pendQ, pendD, extendQ, extendD;
    logic lockQ, lockD, ackQ, ackD, doneQ, doneD;
    logic [2:0] divSelQ, divSelD;
    logic [7:0] selectQ, selectD;
    logic [6:0] activeQ, activeD;
    logic [6:0] prescQ, prescD;
    logic [4:0] cntQ, cntD;
    logic [9:0] resultQ, resultD;
    logic [7:0] readQ, readD;
    adcr_pkg::adcr_route_s routeQ, routeD;

    logic access, writeEn, readEn, tick, finish, lowReq;
    logic [6:0] divLast;
    logic [4:0] convLen;
    logic [7:0] wByte, lowByte, highByte, csByte;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait state: ack is registered, so side effects land on
    // the same edge at which the master samples ack
    assign access = wb_cyc_i && wb_stb_i && ackQ;
    assign writeEn = access && wb_we_i && wb_sel_i[0];
    assign readEn = access && !wb_we_i;
    assign wByte = wb_dat_i[7:0];

    function automatic logic hit(input logic [7:0] adr,
                                 input logic [5:0] idx);
        hit = (adr == {idx, 2'b00});
    endfunction

    // low byte is captured at the request edge, so the pair freezes there:
    // a completion on that very edge must not slip in under the read
    assign lowReq = wb_cyc_i && wb_stb_i && !ackQ && !wb_we_i
                    && hit(wb_adr_i, adcr_pkg::IDX_RESULT_LOW);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_comb begin
        if (divSelQ <= 3'h1) begin
            divLast = 7'h01; // R16
        end else begin
            divLast = 7'((8'h01 << divSelQ) - 8'h01); // R16
        end
    end

    assign tick = enableQ && (prescQ == divLast);
    assign convLen = extendQ ? adcr_pkg::EXTENDED_CYCLES
                             : adcr_pkg::NORMAL_CYCLES; // R20
    assign finish = (stateQ == adcr_pkg::ST_CONVERT) && tick
                    && (cntQ == 5'(convLen - 5'h01));

    always_comb begin
        if (!enableQ || tick) begin
            prescD = 7'h00; // R23
        end else begin
            prescD = 7'(prescQ + 7'h01);
        end
    end

    // ------------------------------------------------------------
    // result presentation
    // ------------------------------------------------------------
    always_comb begin
        if (selectQ[adcr_pkg::SEL_LEFT_JUSTIFY]) begin
            highByte = resultQ[9:2]; // R4 R17
            lowByte = {resultQ[1:0], 6'h00}; // R17
        end else begin
            highByte = {6'h00, resultQ[9:8]}; // R17
            lowByte = resultQ[7:0]; // R17
        end
        // start reads high through pending, dummy and real conversion
        csByte = {enableQ, pendQ || (stateQ == adcr_pkg::ST_CONVERT),
                  freeRunQ, flagQ, doneIeQ, divSelQ}; // R10
    end

    // ------------------------------------------------------------
    // selector decode
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] code;
        logic [8:0] diff;
        code = activeQ[4:0];
        diff = 9'h000;
        routeD = '0;
        routeD.useSupply = (activeQ[6:5] == 2'b00); // R1
        routeD.useExternalPin = (activeQ[6:5] == 2'b01); // R1
        routeD.useInternalRef = activeQ[6]; // R1
        routeD.internalRefWithCap = (activeQ[6:5] == 2'b11); // R1
        // {positive, negative, gain20x}
        case (code)
            5'h0b: diff = {4'h0, 4'h1, 1'b1}; // R5
            5'h0c: diff = {4'h0, 4'h1, 1'b0};
            5'h0d: diff = {4'h1, 4'h1, 1'b1}; // R6
            5'h0e: diff = {4'h2, 4'h1, 1'b1};
            5'h0f: diff = {4'h2, 4'h1, 1'b0};
            5'h10: diff = {4'h2, 4'h3, 1'b0};
            5'h11: diff = {4'h3, 4'h3, 1'b1}; // R6
            5'h12: diff = {4'h4, 4'h3, 1'b1};
            5'h13: diff = {4'h4, 4'h3, 1'b0};
            5'h14: diff = {4'h4, 4'h5, 1'b1};
            5'h15: diff = {4'h4, 4'h5, 1'b0};
            5'h16: diff = {4'h5, 4'h5, 1'b1}; // R6
            5'h17: diff = {4'h6, 4'h5, 1'b1};
            5'h18: diff = {4'h6, 4'h5, 1'b0};
            5'h19: diff = {4'h8, 4'h9, 1'b1};
            5'h1a: diff = {4'h8, 4'h9, 1'b0};
            5'h1b: diff = {4'h9, 4'h9, 1'b1}; // R6
            5'h1c: diff = {4'ha, 4'h9, 1'b1};
            5'h1d: diff = {4'ha, 4'h9, 1'b0};
            default: diff = 9'h000;
        endcase
        if (code <= adcr_pkg::LAST_SINGLE_CODE) begin
            routeD.singleEnded = 1'b1; // R5
            routeD.positiveInput = code[3:0];
        end else if (code == adcr_pkg::BANDGAP_CODE) begin
            routeD.bandgap = 1'b1; // R5
        end else if (code == adcr_pkg::GROUND_CODE) begin
            routeD.ground = 1'b1; // R5
        end else begin
            routeD.differential = 1'b1; // R5
            routeD.positiveInput = diff[8:5];
            routeD.negativeInput = diff[4:1];
            routeD.gain20x = diff[0];
        end
    end

    // ------------------------------------------------------------
    // registers, conversion sequencing and bus side effects
    // ------------------------------------------------------------
    always_comb begin
        stateD = stateQ;
        enableD = enableQ;
        freeRunD = freeRunQ;
        doneIeD = doneIeQ;
        divSelD = divSelQ;
        flagD = flagQ;
        pendD = pendQ;
        extendD = extendQ;
        lockD = lockQ;
        selectD = selectQ;
        activeD = activeQ;
        cntD = cntQ;
        resultD = resultQ;
        doneD = 1'b0;
        ackD = wb_cyc_i && wb_stb_i && !ackQ;
        readD = readQ;

        // selection tracks the register while idle, locked once running
        if (stateQ == adcr_pkg::ST_IDLE) begin
            activeD = {selectQ[7:6], selectQ[4:0]}; // R2
        end

        if (stateQ == adcr_pkg::ST_IDLE) begin
            if (pendQ && tick) begin
                stateD = adcr_pkg::ST_CONVERT; // R21
                pendD = 1'b0;
                cntD = 5'h00;
            end
        end else if (tick) begin
            cntD = 5'(cntQ + 5'h01);
            if (finish) begin
                doneD = 1'b1;
                extendD = 1'b0; // R9
                if (!lockQ && !lowReq) begin
                    resultD = conversionResult; // R19 R22
                end
                cntD = 5'h00;
                activeD = {selectQ[7:6], selectQ[4:0]}; // R2
                if (!freeRunQ) begin
                    stateD = adcr_pkg::ST_IDLE; // R12
                end
            end
        end

        if (vectorTaken) begin
            flagD = 1'b0; // R13
        end

        if (writeEn && hit(wb_adr_i, adcr_pkg::IDX_INPUT_SELECT)) begin
            selectD = wByte; // R2 R4
        end
        if (writeEn && hit(wb_adr_i, adcr_pkg::IDX_CONTROL_STATUS)) begin
            enableD = wByte[adcr_pkg::CS_ENABLE]; // R7
            freeRunD = wByte[adcr_pkg::CS_FREE_RUN]; // R12
            doneIeD = wByte[adcr_pkg::CS_DONE_IE];
            divSelD = wByte[2:0]; // R16
            if (wByte[adcr_pkg::CS_DONE_FLAG]) begin
                flagD = 1'b0; // R13
            end
            if (!enableQ && wByte[adcr_pkg::CS_ENABLE]) begin
                extendD = 1'b1; // R9 R20
            end
            // a zero in the start position leaves pendD untouched
            if (wByte[adcr_pkg::CS_START] && wByte[adcr_pkg::CS_ENABLE]
                && stateQ == adcr_pkg::ST_IDLE) begin
                pendD = 1'b1; // R11 R21
            end
            if (!wByte[adcr_pkg::CS_ENABLE]) begin
                stateD = adcr_pkg::ST_IDLE; // R7
                pendD = 1'b0;
                doneD = 1'b0;
                cntD = 5'h00;
                resultD = resultQ;
            end
        end

        // completion is applied last so a same-cycle clear loses
        if (doneD) begin
            flagD = 1'b1; // R13
        end

        if (lowReq) begin
            lockD = 1'b1; // R22
        end else if (readEn && hit(wb_adr_i, adcr_pkg::IDX_RESULT_HIGH)) begin
            lockD = 1'b0; // R22
        end

        if (wb_cyc_i && wb_stb_i && !ackQ) begin
            if (hit(wb_adr_i, adcr_pkg::IDX_RESULT_LOW)) begin
                readD = lowByte;
            end else if (hit(wb_adr_i, adcr_pkg::IDX_RESULT_HIGH)) begin
                readD = highByte;
            end else if (hit(wb_adr_i, adcr_pkg::IDX_CONTROL_STATUS)) begin
                readD = csByte;
            end else if (hit(wb_adr_i, adcr_pkg::IDX_INPUT_SELECT)) begin
                readD = selectQ;
            end else begin
                readD = 8'h00;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stateQ <= adcr_pkg::ST_IDLE;
            enableQ <= 1'b0;
            freeRunQ <= 1'b0;
            doneIeQ <= 1'b0;
            divSelQ <= 3'h0;
            flagQ <= 1'b0;
            pendQ <= 1'b0;
            extendQ <= 1'b0;
            lockQ <= 1'b0;
            ackQ <= 1'b0;
            doneQ <= 1'b0;
            selectQ <= adcr_pkg::RESET_BYTE;
            activeQ <= 7'h00;
            prescQ <= 7'h00;
            cntQ <= 5'h00;
            resultQ <= 10'h000;
            readQ <= adcr_pkg::RESET_BYTE;
            routeQ <= '0;
        end else begin
            stateQ <= stateD;
            enableQ <= enableD;
            freeRunQ <= freeRunD;
            doneIeQ <= doneIeD;
            divSelQ <= divSelD;
            flagQ <= flagD;
            pendQ <= pendD;
            extendQ <= extendD;
            lockQ <= lockD;
            ackQ <= ackD;
            doneQ <= doneD;
            selectQ <= selectD;
            activeQ <= activeD;
            prescQ <= prescD;
            cntQ <= cntD;
            resultQ <= resultD;
            readQ <= readD;
            routeQ <= routeD;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ackQ;
    assign wb_dat_o = {24'h000000, readQ};
    assign converterOn = enableQ;
    assign converterTick = tick;
    assign converting = (stateQ == adcr_pkg::ST_CONVERT);
    assign conversionDone = doneQ;
    assign analogRoute = routeQ;
    assign doneIrq = flagQ && doneIeQ && globalIntEnable; // R14

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_done;
        doneQ;
    endsequence
    sequence s_flag_up;
        flagQ;
    endsequence

    property p_flag_on_done;
        s_done |-> s_flag_up;
    endproperty
    a_flag_on_done: assert property (p_flag_on_done) // R13
        else $error("done flag not set after completion");

    property p_irq;
        doneQ && doneIeQ && globalIntEnable |-> doneIrq;
    endproperty
    a_irq: assert property (p_irq) // R14
        else $error("interrupt request mismatch");

    property p_abort;
        !enableQ |-> stateQ == adcr_pkg::ST_IDLE && !pendQ;
    endproperty
    a_abort: assert property (p_abort) // R7
        else $error("conversion alive while disabled");

    property p_presc_zero;
        !enableQ |=> prescQ == 7'h00 || enableQ;
    endproperty
    a_presc_zero: assert property (p_presc_zero) // R23
        else $error("prescaler not held at zero");

    property p_locked_sel;
        stateQ == adcr_pkg::ST_CONVERT && !tick |=> $stable(activeQ);
    endproperty
    a_locked_sel: assert property (p_locked_sel) // R2
        else $error("selection changed mid conversion");

    property p_len;
        stateQ == adcr_pkg::ST_CONVERT |-> cntQ < convLen;
    endproperty
    a_len: assert property (p_len) // R20
        else $error("conversion ran past its length");

    property p_freeze;
        lockQ |=> $stable(resultQ);
    endproperty
    a_freeze: assert property (p_freeze) // R22
        else $error("result changed while frozen");

    property p_start_reads;
        stateQ == adcr_pkg::ST_CONVERT |-> csByte[adcr_pkg::CS_START];
    endproperty
    a_start_reads: assert property (p_start_reads) // R10
        else $error("start bit low during conversion");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held two cycles");

endmodule

`default_nettype wire

// ===== verification/adcr_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adcr_control_bench;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
    } adcr_row_s;

    logic clock, resetN, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr, rd;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO;
    logic [9:0] convResult;
    logic globalIe, vectorTaken, converterOn, converterTick;
    logic converting, conversionDone, doneIrq;
    logic [15:0] r;
    logic [1:0] k;
    adcr_pkg::adcr_route_s route;
    int err_total, n_tests, tickCnt, t0, gap;

    // route rows: code, positive, negative, kind (0 single, 1 diff,
    // 2 bandgap, 3 ground), gain
    logic [15:0] rt [13] = '{16'h0000, 16'h5500, 16'h580b, 16'h600a,
        16'h688b, 16'h811a, 16'h899b, 16'hb2ab, 16'hcc4b, 16'hdccb,
        16'hed4a, 16'hf004, 16'hf806};
    adcr_row_s rows [13] = '{'{1'b0, 6'h04, 8'h00, 8'h00},
        '{1'b0, 6'h05, 8'h00, 8'h00}, '{1'b0, 6'h06, 8'h00, 8'h00},
        '{1'b0, 6'h07, 8'h00, 8'h00}, '{1'b0, 6'h08, 8'h00, 8'h00},
        '{1'b1, 6'h07, 8'heb, 8'h00}, '{1'b0, 6'h07, 8'h00, 8'heb},
        '{1'b1, 6'h08, 8'h5a, 8'h00}, '{1'b0, 6'h08, 8'h00, 8'h00},
        '{1'b1, 6'h06, 8'h0b, 8'h00}, '{1'b0, 6'h06, 8'h00, 8'h0b},
        '{1'b1, 6'h06, 8'h00, 8'h00}, '{1'b1, 6'h07, 8'h00, 8'h00}};

    adcr_control adcr_control_i (.clock(clock), .reset_n(resetN),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .conversionResult(convResult), .globalIntEnable(globalIe),
        .vectorTaken(vectorTaken), .converterOn(converterOn),
        .converterTick(converterTick), .converting(converting),
        .conversionDone(conversionDone), .analogRoute(route),
        .doneIrq(doneIrq));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // counts converter ticks seen while a conversion runs
    always @(posedge clock) begin
        if (converting === 1'b1 && converterTick === 1'b1) tickCnt++;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] ex,
                           input string what);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, ex);
        end
    endtask

    task automatic chk_cnt(input int got, input int ex, input string what);
        n_tests++;
        if (got != ex) begin
            err_total++;
            $display("mismatch at %0t: %s got %0d want %0d", $time, what,
                     got, ex);
        end
    endtask

    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic we, input logic [5:0] idx,
                       input logic [7:0] wd);
        int n;
        n = 0;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h000000, wd};
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        @(posedge clock);
        while (wbAck !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        chk_cnt(n < 20, 1, "bus ack");
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (conversionDone !== 1'b1 && n < lim);
        chk_cnt(n < lim, 1, "done pulse");
    endtask

    task automatic tick_gap(output int g);
        int n;
        n = 0;
        g = 0;
        do begin
            @(posedge clock);
            n++;
        end while (converterTick !== 1'b1 && n < 300);
        do begin
            @(posedge clock);
            g++;
        end while (converterTick !== 1'b1 && g < 300);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // run needs well under 10k cycles; this cuts a hang short
    initial begin
        #400000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {resetN, wbCyc, wbStb, wbWe, globalIe, vectorTaken} = 6'h00;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatI = 32'h00000000;
        convResult = 10'h000;
        tickCnt = 0;
        repeat (16) @(posedge clock);
        resetN <= 1'b1;
        @(posedge clock);
        chk_val({converterOn, converting, doneIrq}, 3'h0, "reset outs");
        for (int i = 0; i < 13; i++) begin
            bus(rows[i].we, rows[i].idx, rows[i].wd);
            if (!rows[i].we) chk_val(rd, rows[i].ex, "register read");
        end
        $display("test register rows done");

        for (int i = 0; i < 13; i++) begin
            r = rt[i];
            bus(1'b1, 6'h07, {i[1:0], 1'b0, r[15:11]});
            repeat (2) @(posedge clock);
            k = r[2:1];
            chk_val({route.singleEnded, route.differential, route.bandgap,
                route.ground}, 4'h8 >> k, "input kind");
            chk_val({route.positiveInput,
                route.negativeInput, route.gain20x}, {r[10:3], r[0]},
                "pair");
            chk_val({route.useSupply, route.useExternalPin,
                route.useInternalRef, route.internalRefWithCap},
                {i[1:0] == 2'h0, i[1:0] == 2'h1, i[1],
                i[1:0] == 2'h3}, "reference");
        end
        $display("test input routing done");

        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 6'h06, {5'h10, c[2:0]});
            tick_gap(gap);
            chk_cnt(gap, (c < 2) ? 2 : (1 << c), "divider");
        end
        bus(1'b1, 6'h06, 8'h00);
        gap = 0;
        repeat (140) begin
            @(posedge clock);
            if (converterTick === 1'b1) gap++;
        end
        chk_cnt(gap, 0, "ticks while off");
        $display("test divider done");

        convResult <= 10'h320;
        globalIe <= 1'b1;
        bus(1'b1, 6'h07, 8'h00);
        t0 = tickCnt;
        bus(1'b1, 6'h06, 8'hc8);
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'hc8, "start during dummy");
        wait_done(200);
        chk_cnt(tickCnt - t0, 25, "extended length");
        chk_val(doneIrq, 1'b1, "irq raised");
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h98, "after done");
        bus(1'b0, 6'h04, 8'h00);
        chk_val(rd, 8'h20, "low right");
        bus(1'b0, 6'h05, 8'h00);
        chk_val(rd, 8'h03, "high right");
        globalIe <= 1'b0;
        @(posedge clock);
        chk_val(doneIrq, 1'b0, "irq masked");
        bus(1'b1, 6'h07, 8'h20);
        bus(1'b0, 6'h04, 8'h00);
        chk_val(rd, 8'h00, "low left");
        bus(1'b0, 6'h05, 8'h00);
        chk_val(rd, 8'hc8, "high left");
        vectorTaken <= 1'b1;
        @(posedge clock);
        vectorTaken <= 1'b0;
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h88, "vector clears");
        $display("test first conversion done");

        bus(1'b1, 6'h07, 8'h0b);
        convResult <= 10'h155;
        t0 = tickCnt;
        bus(1'b1, 6'h06, 8'hc0);
        bus(1'b1, 6'h06, 8'h80);
        bus(1'b1, 6'h07, 8'h1d);
        chk_val(converting, 1'b1, "zero start ignored");
        chk_val({route.positiveInput, route.gain20x}, 5'h01, "locked");
        wait_done(100);
        chk_cnt(tickCnt - t0, 13, "normal length");
        repeat (2) @(posedge clock);
        chk_val({route.positiveInput, route.gain20x}, 5'h14, "applied");
        bus(1'b1, 6'h06, 8'h90);
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h80, "write one clears");
        $display("test normal conversion done");

        bus(1'b0, 6'h04, 8'h00);
        chk_val(rd, 8'h55, "low first");
        convResult <= 10'h2aa;
        bus(1'b1, 6'h06, 8'hc0);
        wait_done(100);
        bus(1'b0, 6'h05, 8'h00);
        chk_val(rd, 8'h01, "high kept");
        bus(1'b1, 6'h06, 8'hd0);
        wait_done(100);
        bus(1'b0, 6'h04, 8'h00);
        chk_val(rd, 8'haa, "new low");
        bus(1'b0, 6'h05, 8'h00);
        chk_val(rd, 8'h02, "new high");
        $display("test result pairing done");

        bus(1'b1, 6'h06, 8'hf0);
        wait_done(100);
        wait_done(100);
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'hf0, "free running");
        bus(1'b1, 6'h06, 8'h90);
        repeat (60) @(posedge clock);
        chk_val(converting, 1'b0, "free run ended");
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h90, "start cleared");
        $display("test free running done");

        bus(1'b1, 6'h06, 8'hd0);
        repeat (6) @(posedge clock);
        bus(1'b1, 6'h06, 8'h00);
        chk_val({converterOn, converting}, 2'h0, "abort");
        gap = 0;
        repeat (60) begin
            @(posedge clock);
            if (conversionDone === 1'b1) gap++;
        end
        chk_cnt(gap, 0, "no done after abort");
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h00, "control after abort");
        $display("test abort done");

        bus(1'b1, 6'h06, 8'hc0);
        repeat (5) @(posedge clock);
        resetN <= 1'b0;
        @(posedge clock);
        chk_val({converterOn, converting}, 2'h0, "mid-run reset");
        repeat (3) @(posedge clock);
        resetN <= 1'b1;
        @(posedge clock);
        bus(1'b0, 6'h07, 8'h00);
        chk_val(rd, 8'h00, "select after reset");
        bus(1'b0, 6'h06, 8'h00);
        chk_val(rd, 8'h00, "control after reset");
        $display("test second reset done");
        close_out();
    end

endmodule

`default_nettype wire
